/* logic/caq_pkg.sv */
`default_nettype none
package caq_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int TICK_US = 1000;                                 // sampling tick period, one millisecond
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;     // cycles per tick
   localparam int STRETCH_MS = 10;                                // trigger minimum low interval
   localparam int PRESENT_GUARD_MS = 20;                          // tone-present guard time
   localparam int ABSENT_GUARD_MS = 16;                           // tone-absent guard time
   localparam int ABSENT_DETECT_MAX_MS = 8;                       // longest tone-absent detect delay
   localparam int ABSENT_DETECT_CYCLES = CLK_HZ / 1000 * ABSENT_DETECT_MAX_MS;
   localparam int RING_MIN_MS = 200;                              // single ring burst, shortest
   localparam int RING_MAX_MS = 450;                              // single ring burst, longest
   localparam int CNT_W = 16;                                     // guard and stretch counter width
endpackage : caq_pkg
`default_nettype wire

/* logic/caq_link_if.sv */
`default_nettype none
// pins between the qualifier and the host controller
interface caq_link_if;
   logic call_event_output_n;
   logic early_tone_detect;
   logic qualified_tone_detect;
   logic word_ready_n;
   logic event_request_n;
   logic guard_disable_switch;
   logic [15:0] present_guard_time;
   logic [15:0] absent_guard_time;
   logic [15:0] stretch_time;
   modport dev (
      output call_event_output_n, early_tone_detect, qualified_tone_detect, event_request_n,
      input word_ready_n, guard_disable_switch, present_guard_time, absent_guard_time, stretch_time
   );
   modport host (
      input call_event_output_n, early_tone_detect, qualified_tone_detect, event_request_n,
      output word_ready_n, guard_disable_switch, present_guard_time, absent_guard_time, stretch_time
   );
endinterface : caq_link_if
`default_nettype wire

/* logic/caq_device.sv */
`default_nettype none
// Behaviour
// RULE1: trigger output low on line event
// RULE2: trigger returns high after event and stretch
// RULE3: trigger stays low minimum stretch interval
// RULE4: envelope: low while stretch node held
// RULE5: zero stretch: low only during event
// RULE6: ring burst 200-450 ms recognised
// RULE7: host may wake on trigger fall
// RULE8: low and high tones assessed separately
// RULE9: early detect high when both tones
// RULE10: early detect low when tones stop
// RULE11: qualified after present guard time
// RULE12: dropouts shorter than absent guard ignored
// RULE13: recognition equals guard plus detect delay
// RULE14: absent time equals guard plus delay
// RULE15: host sets present guard >= 20 ms
// RULE16: host applies load at qualified fall
// RULE17: host sets present guard above absent
// RULE18: guard disable holds qualified output low
// RULE19: steering threshold sets output, re-arms
// RULE20: event request while any source active
// RULE21: guards and stretch are tick counters
// RULE22: inputs synchronised before use; word_ready_n and guard_disable_switch are used without a synchroniser
module caq_device #(
   parameter int TICK_LEN = caq_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic SRST,
   // line front end and tone filters
   input wire logic LINE_EVENT_INPUT,
   input wire logic LOW_TONE_PRESENT,
   input wire logic HIGH_TONE_PRESENT,
   // host side
   caq_link_if.dev LINK
);
   import caq_pkg::*;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   // two flops per input, first stage read only by the second
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {LINE_EVENT_INPUT, LOW_TONE_PRESENT, HIGH_TONE_PRESENT}; // RULE22
         sync_b <= sync_a;
      end
   end
   wire line_event = sync_b[2];
   wire low_tone = sync_b[1];  // RULE8
   wire high_tone = sync_b[0]; // RULE8

   // ------------------------------------------------------------
   // sampling tick
   // ------------------------------------------------------------
   logic [31:0] tick_cnt;
   wire tick = (tick_cnt == 32'(TICK_LEN - 1));
   // free running millisecond tick
   always_ff @(posedge SYS_CLK) begin
      if (SRST) tick_cnt <= 32'h0;
      else if (tick) tick_cnt <= 32'h0;
      else tick_cnt <= tick_cnt + 32'h1;
   end

   // ------------------------------------------------------------
   // trigger path
   // ------------------------------------------------------------
   logic [CNT_W-1:0] stretch_cnt;
   // node is pulled low while the event is present, then recharges
   wire stretch_node_low = line_event || (stretch_cnt != '0); // RULE4
   always_ff @(posedge SYS_CLK) begin
      if (SRST) stretch_cnt <= '0;
      else if (line_event) stretch_cnt <= LINK.stretch_time;      // RULE3 RULE21
      else if (tick && stretch_cnt != '0) stretch_cnt <= stretch_cnt - 1'b1; // RULE2
   end
   // low during event or stretch; zero stretch gives the raw envelope
   logic trig_n;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) trig_n <= 1'b1;
      else trig_n <= ~stretch_node_low; // RULE1 RULE5 RULE6
   end
   assign LINK.call_event_output_n = trig_n;

   // ------------------------------------------------------------
   // dual tone alert detector
   // ------------------------------------------------------------
   logic early;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) early <= 1'b0;
      else early <= low_tone && high_tone; // RULE9 RULE10
   end
   assign LINK.early_tone_detect = early;

   // ------------------------------------------------------------
   // guard time qualification
   // ------------------------------------------------------------
   logic steer;
   logic [CNT_W-1:0] guard_cnt;
   wire disagree = (early != steer);
   wire [CNT_W-1:0] limit = steer ? LINK.absent_guard_time : LINK.present_guard_time;
   // counter runs while early disagrees with steering state, resets on agreement
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         guard_cnt <= '0;
         steer <= 1'b0;
      end else if (!disagree) begin
         guard_cnt <= '0; // RULE12
      end else if (guard_cnt >= limit) begin
         steer <= early; // RULE11 RULE19
         guard_cnt <= '0;
      end else if (tick) begin
         guard_cnt <= guard_cnt + 1'b1; // RULE21 RULE13 RULE14
      end
   end
   logic qual;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) qual <= 1'b0;
      else qual <= steer && !LINK.guard_disable_switch; // RULE18
   end
   assign LINK.qualified_tone_detect = qual;

   // ------------------------------------------------------------
   // event request
   // ------------------------------------------------------------
   logic req_n;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) req_n <= 1'b1;
      else req_n <= ~(~trig_n || ~LINK.word_ready_n || qual); // RULE20
   end
   assign LINK.event_request_n = req_n;
endmodule : caq_device
`default_nettype wire

/* logic/caq_host.sv */
`default_nettype none
// host end: sets guard times, reports events and wetting pulse moment
module caq_host (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic SRST,
   // user configuration
   input wire logic DISABLE_ALERT,
   input wire logic [15:0] PRESENT_GUARD,
   input wire logic [15:0] ABSENT_GUARD,
   input wire logic [15:0] STRETCH,
   input wire logic WORD_READY_N,
   // user results
   output logic WAKE,
   output logic ALERT_END,
   output logic ALERT_ACTIVE,
   // device side
   caq_link_if.host LINK
);
   import caq_pkg::*;

   // ------------------------------------------------------------
   // configuration drive
   // ------------------------------------------------------------
   // present guard kept at least the minimum and above the absent guard
   wire [15:0] pg_min = (PRESENT_GUARD < 16'(PRESENT_GUARD_MS)) ? 16'(PRESENT_GUARD_MS) : PRESENT_GUARD; // RULE15
   wire [15:0] pg = (pg_min <= ABSENT_GUARD) ? ABSENT_GUARD + 16'h1 : pg_min; // RULE17
   assign LINK.present_guard_time = pg;
   assign LINK.absent_guard_time = ABSENT_GUARD;
   assign LINK.stretch_time = STRETCH;
   assign LINK.guard_disable_switch = DISABLE_ALERT;
   assign LINK.word_ready_n = WORD_READY_N;

   // ------------------------------------------------------------
   // edge detection
   // ------------------------------------------------------------
   logic trig_d;
   logic qual_d;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         trig_d <= 1'b1;
         qual_d <= 1'b0;
         WAKE <= 1'b0;
         ALERT_END <= 1'b0;
         ALERT_ACTIVE <= 1'b0;
      end else begin
         trig_d <= LINK.call_event_output_n;
         qual_d <= LINK.qualified_tone_detect;
         WAKE <= trig_d && !LINK.call_event_output_n; // RULE7
         ALERT_END <= qual_d && !LINK.qualified_tone_detect; // RULE16
         ALERT_ACTIVE <= LINK.qualified_tone_detect;
      end
   end
endmodule : caq_host
`default_nettype wire

/* verif/caq_link_properties.sv */
`default_nettype none
// watches the link between the two ends
module caq_link_properties (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic SRST,
   // front end
   input wire logic LINE_EVENT_INPUT,
   input wire logic LOW_TONE_PRESENT,
   input wire logic HIGH_TONE_PRESENT,
   // link
   input wire logic call_event_output_n,
   input wire logic early_tone_detect,
   input wire logic qualified_tone_detect,
   input wire logic event_request_n,
   input wire logic word_ready_n,
   input wire logic guard_disable_switch,
   input wire logic [15:0] stretch_time
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   sequence s_both; LOW_TONE_PRESENT && HIGH_TONE_PRESENT; endsequence
   sequence s_idle; call_event_output_n && word_ready_n && !qualified_tone_detect; endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_trig_low; LINE_EVENT_INPUT[*3] |=> !call_event_output_n; endproperty
   property p_trig_high; (stretch_time == 16'h0) throughout (!LINE_EVENT_INPUT[*4]) |=> call_event_output_n; endproperty
   property p_early_set; s_both[*3] |=> early_tone_detect; endproperty
   property p_early_clr; (!(LOW_TONE_PRESENT && HIGH_TONE_PRESENT))[*3] |=> !early_tone_detect; endproperty
   property p_disable; guard_disable_switch |=> !qualified_tone_detect; endproperty
   property p_qual; $rose(qualified_tone_detect) |-> $past(early_tone_detect, 8); endproperty
   property p_req_set; (!call_event_output_n || qualified_tone_detect) |=> !event_request_n; endproperty
   property p_req_word; (!word_ready_n)[*4] |=> !event_request_n; endproperty
   property p_req_clr; s_idle[*5] |=> event_request_n; endproperty
   a_trig_low: assert property (p_trig_low) else $error("trigger not low");
   a_trig_high: assert property (p_trig_high) else $error("trigger not high");
   a_early_set: assert property (p_early_set) else $error("early not set");
   a_early_clr: assert property (p_early_clr) else $error("early not clear");
   a_disable: assert property (p_disable) else $error("qualified while off");
   a_qual: assert property (p_qual) else $error("qualified without early");
   a_req_set: assert property (p_req_set) else $error("request missing");
   a_req_word: assert property (p_req_word) else $error("request on word");
   a_req_clr: assert property (p_req_clr) else $error("request stuck");
endmodule // caq_link_properties
`default_nettype wire

/* verif/call_alert_event_qualifier_tb.sv */
`default_nettype none
module call_alert_event_qualifier_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0, srst = 1'b1, ev = 1'b0, lo = 1'b0, hi = 1'b0, dis = 1'b0, wr_n = 1'b1;
   logic wake, alert_end, alert_active;
   int n_errors = 0, n_tests = 0, n_cyc = 0, n_wake = 0, n_end = 0;
   caq_link_if link ();
   caq_device #(.TICK_LEN(10)) caq_device_i (.SYS_CLK(sys_clk), .SRST(srst), .LINE_EVENT_INPUT(ev), .LOW_TONE_PRESENT(lo),
      .HIGH_TONE_PRESENT(hi), .LINK(link));
   caq_host caq_host_i (.SYS_CLK(sys_clk), .SRST(srst), .DISABLE_ALERT(dis), .PRESENT_GUARD(16'h0014),
      .ABSENT_GUARD(16'h0010), .STRETCH(16'h0000), .WORD_READY_N(wr_n), .WAKE(wake), .ALERT_END(alert_end),
      .ALERT_ACTIVE(alert_active), .LINK(link));
   caq_link_properties caq_link_properties_i (.SYS_CLK(sys_clk), .SRST(srst), .LINE_EVENT_INPUT(ev),
      .LOW_TONE_PRESENT(lo), .HIGH_TONE_PRESENT(hi), .call_event_output_n(link.call_event_output_n),
      .early_tone_detect(link.early_tone_detect), .qualified_tone_detect(link.qualified_tone_detect),
      .event_request_n(link.event_request_n), .word_ready_n(link.word_ready_n),
      .guard_disable_switch(link.guard_disable_switch), .stretch_time(link.stretch_time));
   // clock
   always #2.5 sys_clk = ~sys_clk;
   // wake pulse count and hang limit
   always @(posedge sys_clk) begin
      n_cyc <= n_cyc + 1;
      if (wake === 1'b1) n_wake <= n_wake + 1;
      if (alert_end === 1'b1) n_end <= n_end + 1;
      if (n_cyc == 5000) begin
         n_errors = n_errors + 1;
         test_done();
      end
   end
   // drive front end, hold n edges, sample settled
   task automatic step(input logic e, l, h, input int n);
      @(posedge sys_clk);
      ev <= e; lo <= l; hi <= h;
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      step(0, 0, 0, 2);
      chk(1'b1, link.call_event_output_n);
      chk(1'b1, link.event_request_n);
      chk(1'b0, alert_active);
      $display("test reset done");
      step(1, 0, 0, 4);
      chk(1'b0, link.call_event_output_n);
      step(1, 0, 0, 10);
      chk(1'b0, link.event_request_n);
      step(0, 0, 0, 8);
      chk(1'b1, link.call_event_output_n);
      chk(1'b1, link.event_request_n);
      chk(1'b1, n_wake == 1);
      $display("test trigger done");
      step(0, 1, 0, 8);
      chk(1'b0, link.early_tone_detect);
      step(0, 1, 1, 4);
      chk(1'b1, link.early_tone_detect);
      step(0, 1, 1, 20);
      chk(1'b0, link.qualified_tone_detect);
      step(0, 0, 1, 4);
      chk(1'b0, link.early_tone_detect);
      step(0, 1, 1, 300);
      chk(1'b1, link.qualified_tone_detect);
      chk(1'b1, alert_active);
      chk(1'b0, link.event_request_n);
      step(0, 0, 1, 50);
      step(0, 1, 1, 20);
      chk(1'b1, link.qualified_tone_detect);
      step(0, 0, 0, 300);
      chk(1'b0, link.qualified_tone_detect);
      chk(1'b1, n_end == 1);
      $display("test tones done");
      @(posedge sys_clk);
      dis <= 1'b1;
      step(0, 1, 1, 300);
      chk(1'b1, link.early_tone_detect);
      chk(1'b0, link.qualified_tone_detect);
      step(0, 0, 0, 300);
      @(posedge sys_clk);
      dis <= 1'b0;
      step(0, 0, 0, 6);
      $display("test disable done");
      @(posedge sys_clk);
      wr_n <= 1'b0;
      step(0, 0, 0, 8);
      chk(1'b0, link.event_request_n);
      @(posedge sys_clk);
      wr_n <= 1'b1;
      step(0, 0, 0, 8);
      chk(1'b1, link.event_request_n);
      $display("test request done");
      test_done();
   end
endmodule // call_alert_event_qualifier_tb
`default_nettype wire
